// file: core/ise_pkg.sv
// Constants and types shared by the two-wire slave port files.
// Assumes a 125 MHz system clock and a master-driven serial clock.
package ise_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h60; // Address with pin low
  localparam int ADDR_PIN_POS = 0;                // Address bit set by pin
  localparam int MEM_ADDR_W = 8;                  // Memory address width
  localparam int ROW_BITS = 3;                    // Eight-byte write row
  localparam logic [MEM_ADDR_W-1:0] ADDR_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bit slot counts within one byte frame
  localparam logic [3:0] BIT_LAST = 4'h7;  // Eighth data bit
  localparam logic [3:0] BIT_ACK = 4'h8;   // Acknowledge slot
  localparam logic [3:0] BIT_CHECK = 4'h9; // Master acknowledge sampled
  localparam logic [3:0] BIT_ONE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int NV_WRITE_TIME_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * CLK_FREQ_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine
  typedef enum logic [2:0] {
    ISE_IDLE = 3'b000,
    ISE_ADDR = 3'b001,
    ISE_MEMA = 3'b010,
    ISE_WDATA = 3'b011,
    ISE_RDATA = 3'b100
  } ise_state_t;

endpackage

// file: core/ise_link_if.sv
// Crossing signals between the serial-clock engine and the system side.
// Assumes the link side holds write address and data stable between
// toggles, which are at least nine serial clocks apart.
`timescale 1ns/1ps
interface ise_link_if;
  logic start_tgl; // Flips once per START seen on the system clock
  logic wr_tgl;    // Flips once per acknowledged data byte
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic busy;      // Nonvolatile write in progress

  // Serial-clock engine end
  modport link (
    input start_tgl,
    input busy,
    output wr_tgl,
    output wr_addr,
    output wr_data
  );

  // System-clock end
  modport sys (
    output start_tgl,
    output busy,
    input wr_tgl,
    input wr_addr,
    input wr_data
  );
endinterface

// file: core/ise_sys_ctl.sv
// System-clock side: bus condition detection, write events, write timer.
// Assumes serial pins are asynchronous and START hold exceeds 4 clocks.
`timescale 1ns/1ps
module ise_sys_ctl import ise_pkg::*; #(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Raw pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic load_enable_input_i,
  // Link side
  ise_link_if.sys lnk,
  // User side
  output logic dac_wr_o,
  output logic [7:0] dac_addr_o,
  output logic [7:0] dac_data_o,
  output logic nv_write_o
);

  localparam int TW = $clog2(NV_CYCLES + 1);

  logic [2:0] pin_m_q, pin_s_q;
  logic scl_prev_q, sda_prev_q;
  logic wr_m_q, wr_s_q, wr_last_q;
  logic start_tgl_q, start_tgl_d;
  logic pend_q, pend_d;
  logic [TW-1:0] timer_q, timer_d;
  logic busy_q, busy_d;
  logic dac_wr_d, nv_write_d;
  logic [7:0] dac_addr_d, dac_data_d;
  logic scl_s, sda_s, ld_s, start_evt, stop_evt, wr_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin levels and event decode
  assign scl_s = pin_s_q[2];
  assign sda_s = pin_s_q[1];
  assign ld_s = pin_s_q[0];
  assign start_evt = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_evt = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign wr_evt = wr_s_q ^ wr_last_q;

  // Next values of control state
  always_comb begin
    start_tgl_d = start_tgl_q ^ start_evt;
    dac_wr_d = wr_evt & ld_s;
    dac_addr_d = wr_evt ? lnk.wr_addr : dac_addr_o;
    dac_data_d = wr_evt ? lnk.wr_data : dac_data_o;
    pend_d = pend_q | wr_evt;
    nv_write_d = 1'b0;
    timer_d = (timer_q != '0) ? TW'(timer_q - 1'b1) : timer_q;
    if (stop_evt && pend_d) begin
      nv_write_d = 1'b1;
      timer_d = TW'(NV_CYCLES);
      pend_d = 1'b0;
    end
    busy_d = (timer_d != '0);
  end

  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pin_m_q <= 3'h7;
      pin_s_q <= 3'h7;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      wr_m_q <= 1'b0;
      wr_s_q <= 1'b0;
      wr_last_q <= 1'b0;
      start_tgl_q <= 1'b0;
      pend_q <= 1'b0;
      timer_q <= '0;
      busy_q <= 1'b0;
      dac_wr_o <= 1'b0;
      dac_addr_o <= 8'h00;
      dac_data_o <= 8'h00;
      nv_write_o <= 1'b0;
    end else if (clk_en_i) begin
      pin_m_q <= {scl_i, sda_i, load_enable_input_i};
      pin_s_q <= pin_m_q;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      wr_m_q <= lnk.wr_tgl;
      wr_s_q <= wr_m_q;
      wr_last_q <= wr_s_q;
      start_tgl_q <= start_tgl_d;
      pend_q <= pend_d;
      timer_q <= timer_d;
      busy_q <= busy_d;
      dac_wr_o <= dac_wr_d;
      dac_addr_o <= dac_addr_d;
      dac_data_o <= dac_data_d;
      nv_write_o <= nv_write_d;
    end
  end

  assign lnk.start_tgl = start_tgl_q;
  assign lnk.busy = busy_q;

endmodule

// file: core/ise_slave_port.sv
// Two-wire slave port with an eight-bit memory address counter.
// Assumes an external master makes the serial clock and pull-ups exist;
// the bit engine runs on the serial clock, the rest on the system clock.
`timescale 1ns/1ps

// Operation
// - SDA falling while SCL high starts transfer
// - SDA rising while SCL high ends transfer
// - Incoming bits sampled on SCL rising edge
// - Outgoing bits driven on SCL falling edge
// - Ninth bit is acknowledge, low means ACK
// - Bytes are eight bits, MSB first
// - Master NACK on last byte releases SDA
// - First byte: seven address bits plus direction
// - Address pin sets one slave address bit
// - Wrong address ignored until next START
// - Second write byte loads address counter
// - Load enable updates output; NV after STOP
// - One to eight bytes, counter advances
// - Writes wrap inside aligned eight-byte row
// - Busy after NV write, address not acknowledged
// - Plain read uses current address counter
// - Dummy write then repeated START reads there
// - Reads continue while master acknowledges
module ise_slave_port import ise_pkg::*; #(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  // System clock, reset and enable
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Strap and control pins
  input wire logic address_select_pin_i,
  input wire logic load_enable_input_i,
  // Converter update and nonvolatile write requests
  output logic dac_wr_o,
  output logic [7:0] dac_addr_o,
  output logic [7:0] dac_data_o,
  output logic nv_write_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ise_link_if lnk ();

  // Level synchronisers into the serial-clock domain
  // Bit 3 reset, bit 2 enable, bit 1 address pin, bit 0 busy
  logic [3:0] lvl_m_q;
  logic [3:0] lvl_s_q;
  logic rst_n_link, ce_link, asel_link, busy_link;

  // START toggle crossing and rising-edge data sample
  logic start_m_q;
  logic start_s_q;
  logic sda_pos_q;

  // Engine state
  ise_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic [MEM_ADDR_W-1:0] addr_q, addr_d;
  logic start_last_q, start_last_d;
  logic oe_q, oe_d;
  logic wr_tgl_q, wr_tgl_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [7:0] wr_data_q, wr_data_d;
  logic mem_we;

  // Mirror of written bytes, read back over the bus
  logic [7:0] mem_q [0:(1 << MEM_ADDR_W)-1];
  logic [MEM_ADDR_W-1:0] rd_ptr;
  logic [7:0] rd_byte;
  logic [7:0] byte_in;
  logic [6:0] own_addr;
  logic addr_hit;
  logic start_seen;

  ////////////////////////////////////////////////////////////////////////////
  // System-clock side

  // START and STOP detection, write events and write timer
  ise_sys_ctl #(
    .NV_CYCLES(NV_CYCLES)
  ) u_sys (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .load_enable_input_i(load_enable_input_i),
    .lnk(lnk.sys),
    .dac_wr_o(dac_wr_o),
    .dac_addr_o(dac_addr_o),
    .dac_data_o(dac_data_o),
    .nv_write_o(nv_write_o)
  );

  // Busy flag seen by the user, registered on the system clock
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else if (clk_en_i) begin
      busy_o <= lnk.busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial-clock synchronisers

  // The serial clock only runs while a master is active, so these levels
  // move on its falling edges. Reset reaches the engine two falling edges
  // late and leaves it two edges late as well: the master must clock the
  // bus at least twice after reset before its first START.
  // Levels from other domains pass two falling-edge flops
  always_ff @(negedge scl_i) begin
    lvl_m_q <= {reset_n_i, clk_en_i, address_select_pin_i, lnk.busy};
    lvl_s_q <= lvl_m_q;
  end

  assign rst_n_link = lvl_s_q[3];
  assign ce_link = lvl_s_q[2];
  assign asel_link = lvl_s_q[1];
  assign busy_link = lvl_s_q[0];

  // The system side must flip the toggle before the master drops the
  // clock after a START, which the START hold time leaves room for.
  // START toggle: falling edge first stage, rising edge second stage,
  // so the engine sees it at the falling edge after the first data bit
  always_ff @(negedge scl_i) begin
    start_m_q <= lnk.start_tgl;
  end

  // Data is stable while the clock is high, so it needs no synchroniser
  always_ff @(posedge scl_i) begin
    start_s_q <= start_m_q;
    if (ce_link) begin
      sda_pos_q <= sda_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine, evaluated at every falling edge of the serial clock

  // Slave address with the strap bit inserted
  always_comb begin
    own_addr = SLAVE_ADDR_BASE;
    own_addr[ADDR_PIN_POS] = asel_link;
  end

  // A busy device drops off the bus for the whole address byte; the
  // master sees a missing acknowledge and polls again later.
  // Completed byte, MSB first, and the address comparison
  assign byte_in = {shreg_q[6:0], sda_pos_q};
  assign addr_hit = (byte_in[7:1] == own_addr) && !busy_link;
  assign start_seen = (start_s_q != start_last_q);

  // After a master ACK the next byte comes from the advanced counter
  assign rd_ptr = (state_q == ISE_RDATA && cnt_q == BIT_CHECK) ?
                  MEM_ADDR_W'(addr_q + 1'b1) : addr_q;
  assign rd_byte = mem_q[rd_ptr];

  // Next-state and drive decisions
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    addr_d = addr_q;
    start_last_d = start_s_q;
    oe_d = 1'b0;
    wr_tgl_d = wr_tgl_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    mem_we = 1'b0;
    if (start_seen) begin
      // First address bit was sampled on the rising edge just past
      state_d = ISE_ADDR;
      shreg_d = byte_in;
      cnt_d = BIT_ONE;
    end else begin
      unique case (state_q)
        ISE_IDLE: begin
          cnt_d = 4'h0;
        end
        ISE_ADDR, ISE_MEMA, ISE_WDATA: begin
          if (cnt_q < BIT_LAST) begin
            shreg_d = byte_in;
            cnt_d = 4'(cnt_q + BIT_ONE);
          end else if (cnt_q == BIT_LAST) begin
            shreg_d = byte_in;
            cnt_d = BIT_ACK;
            if (state_q != ISE_ADDR || addr_hit) begin
              oe_d = 1'b1;
            end else begin
              state_d = ISE_IDLE;
            end
          end else begin
            // Acknowledge slot has passed; act on the received byte
            cnt_d = 4'h0;
            if (state_q == ISE_ADDR) begin
              if (shreg_q[0]) begin
                state_d = ISE_RDATA;
                oe_d = !rd_byte[7];
                cnt_d = BIT_ONE;
              end else begin
                state_d = ISE_MEMA;
              end
            end else if (state_q == ISE_MEMA) begin
              addr_d = shreg_q;
              state_d = ISE_WDATA;
            end else begin
              mem_we = 1'b1;
              wr_tgl_d = !wr_tgl_q;
              wr_addr_d = addr_q;
              wr_data_d = shreg_q;
              // Advance inside the aligned row only
              // Row bits stay fixed; only the low three bits count
              addr_d = {addr_q[MEM_ADDR_W-1:ROW_BITS],
                        ROW_BITS'(addr_q[ROW_BITS-1:0] + 1'b1)};
            end
          end
        end
        ISE_RDATA: begin
          if (cnt_q < BIT_ACK) begin
            oe_d = !rd_byte[~cnt_q[2:0]];
            cnt_d = 4'(cnt_q + BIT_ONE);
          end else if (cnt_q == BIT_ACK) begin
            cnt_d = BIT_CHECK;
          end else begin
            // A NACK still advances, so a plain read goes on from here
            addr_d = rd_ptr;
            if (!sda_pos_q) begin
              oe_d = !rd_byte[7];
              cnt_d = BIT_ONE;
            end else begin
              state_d = ISE_IDLE;
              cnt_d = 4'h0;
            end
          end
        end
        default: begin
          state_d = ISE_IDLE;
          cnt_d = 4'h0;
        end
      endcase
    end
  end

  // Engine registers, all on the falling edge
  always_ff @(negedge scl_i) begin
    if (!rst_n_link) begin
      state_q <= ISE_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      addr_q <= ADDR_RESET;
      start_last_q <= 1'b0;
      oe_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      sda_o <= 1'b0;
    end else if (ce_link) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      addr_q <= addr_d;
      start_last_q <= start_last_d;
      oe_q <= oe_d;
      wr_tgl_q <= wr_tgl_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      sda_o <= 1'b0;
    end
  end

  // The mirror is not reset; a location never written reads back as
  // unknown data, so software must write before it reads.
  // Mirror write on the acknowledged data byte
  always_ff @(negedge scl_i) begin
    if (rst_n_link && ce_link && mem_we) begin
      mem_q[addr_q] <= shreg_q;
    end
  end

  // Open-drain drive: only ever pulls low
  assign sda_oe_o = oe_q;

  // Hand-off to the system side
  assign lnk.wr_tgl = wr_tgl_q;
  assign lnk.wr_addr = wr_addr_q;
  assign lnk.wr_data = wr_data_q;

endmodule

// file: test/ise_slave_port_checker.sv
// Concurrent checks on the slave port's top-level pins.
// Assumes one system clock domain and a small write-time parameter.
`timescale 1ns/1ps
module ise_slave_port_checker import ise_pkg::*; #(
  parameter int NV_CYCLES = NV_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Watched pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic load_enable_input_i,
  input wire logic dac_wr_o,
  input wire logic nv_write_o,
  input wire logic busy_o
);
  int busy_cnt_q;
  int busy_cnt_d;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // Length of the current busy stretch
  always_comb begin
    busy_cnt_d = busy_o ? busy_cnt_q + 1 : 0;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_d;
  end

  ////////////////////////////////////////////////////////////
  sda_low_a: assert property (!sda_o)
    else $error("sda output not low");
  dac_pulse_a: assert property (dac_wr_o |=> !dac_wr_o)
    else $error("converter strobe longer than one cycle");
  dac_load_a: assert property (dac_wr_o |-> load_enable_input_i)
    else $error("converter strobe without load enable");
  nv_busy_a: assert property (nv_write_o |-> ##[1:3] busy_o)
    else $error("busy not raised after write request");
  busy_hold_a: assert property ($rose(busy_o) |-> busy_o[*8])
    else $error("busy dropped early");
  busy_max_a: assert property (busy_o |-> busy_cnt_q <= NV_CYCLES + 1)
    else $error("busy too long");
  busy_min_a: assert property ($fell(busy_o) |->
    busy_cnt_q >= NV_CYCLES - 1)
    else $error("busy too short");
  busy_nak_a: assert property (busy_o |-> !sda_oe_o)
    else $error("data line driven while busy");
  oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
endmodule

bind ise_slave_port ise_slave_port_checker #(.NV_CYCLES(NV_CYCLES)) i_chk (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .load_enable_input_i(load_enable_input_i),
  .dac_wr_o(dac_wr_o),
  .nv_write_o(nv_write_o),
  .busy_o(busy_o)
);

// file: test/ise_master_model.sv
// Behavioural two-wire bus master that makes the serial clock.
// Assumes a pull-up on the data line; clock idles high between frames.
`timescale 1ns/1ps
module ise_master_model (
  // Bus pins
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Both lines idle high outside frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Clock pulses with data high, used while reset is held and again after its release
  task automatic pulses(input int n);
    repeat (n) begin
      #16 scl_o = 1'b0;
      #16 scl_o = 1'b1;
    end
  endtask

  // START or repeated START, falling data while clock high
  task automatic start();
    sda_o = 1'b1;
    #8 scl_o = 1'b1;
    #40 sda_o = 1'b0;
    #40 scl_o = 1'b0;
    #8;
  endtask

  // STOP, rising data while clock high, then bus-free time
  task automatic stop();
    sda_o = 1'b0;
    #8 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #40;
  endtask

  // One slot: data moves in the low phase, sampled while high
  task automatic bit_slot(input logic b, output logic r);
    sda_o = b;
    #8 scl_o = 1'b1;
    #8 r = sda_i;
    #8 scl_o = 1'b0;
    #8;
  endtask

  // Byte out MSB first, slave's answer in the ninth slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, ack);
  endtask

  // Byte in with line released, then master ACK or NACK
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack, r);
  endtask
endmodule

// file: test/ise_slave_port_test.sv
// Self-checking bench for the two-wire slave port.
// Assumes the master model above and a 64-cycle write time.
`timescale 1ns/1ps
module ise_slave_port_test;
  localparam int NV = 64;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pin = 1'b0;
  logic ld = 1'b1;
  logic scl, sda_m, sda_oe, sda_drv, dac_wr, nv_wr, busy;
  logic [7:0] dac_a, dac_d;
  wire sda = sda_m & ~sda_oe;
  int n_fail = 0;
  int tests_run = 0;
  int n_dac = 0;
  int n_nv = 0;

  // System clock, 8 ns period
  always #4 clk_sys_i = ~clk_sys_i;

  ise_slave_port #(.NV_CYCLES(NV)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe),
    .address_select_pin_i(pin), .load_enable_input_i(ld),
    .dac_wr_o(dac_wr), .dac_addr_o(dac_a), .dac_data_o(dac_d),
    .nv_write_o(nv_wr), .busy_o(busy));
  ise_master_model i_mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

  // Count converter strobes and write requests
  always @(posedge clk_sys_i) begin
    if (dac_wr === 1'b1) n_dac++;
    if (nv_wr === 1'b1) n_nv++;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  // Wait out the write time under a bound
  task automatic wait_free();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_sys_i);
    chk_bit(busy, 1'b0);
  endtask
  // Dummy write to set the counter, then repeated START read
  task automatic set_addr(input logic [7:0] a);
    logic k;
    i_mst.start();
    i_mst.wr_byte(8'hC0, k);
    i_mst.wr_byte(a, k);
    i_mst.start();
    i_mst.wr_byte(8'hC1, k);
    chk_bit(k, 1'b0);
  endtask

  task automatic t_write_read();
    logic k;
    logic [7:0] d;
    i_mst.start();
    i_mst.wr_byte(8'hC0, k);
    chk_bit(k, 1'b0);
    i_mst.wr_byte(8'h05, k);
    chk_bit(k, 1'b0);
    i_mst.wr_byte(8'hAA, k);
    repeat (8) @(posedge clk_sys_i);
    chk_byte(dac_a, 8'h05);
    chk_byte(dac_d, 8'hAA);
    i_mst.wr_byte(8'hBB, k);
    chk_bit(k, 1'b0);
    i_mst.stop();
    repeat (8) @(posedge clk_sys_i);
    chk_byte(8'(n_nv), 8'h01);
    chk_bit(busy, 1'b1);
    i_mst.start();
    i_mst.wr_byte(8'hC1, k);
    chk_bit(k, 1'b1);
    i_mst.stop();
    wait_free();
    set_addr(8'h05);
    i_mst.rd_byte(1'b1, d);
    chk_byte(d, 8'hAA);
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte(8'hC1, k);
    i_mst.rd_byte(1'b1, d);
    chk_byte(d, 8'hBB);
    i_mst.stop();
    chk_byte(8'(n_nv), 8'h01);
    $display("test write_read done");
  endtask

  task automatic t_wrap();
    logic k;
    logic [7:0] d;
    n_dac = 0;
    i_mst.start();
    i_mst.wr_byte(8'hC0, k);
    i_mst.wr_byte(8'h0E, k);
    for (int i = 1; i <= 3; i++) begin
      i_mst.wr_byte(8'h11 * 8'(i), k);
      chk_bit(k, 1'b0);
    end
    repeat (8) @(posedge clk_sys_i);
    chk_byte(dac_a, 8'h08);
    chk_byte(8'(n_dac), 8'h03);
    i_mst.stop();
    wait_free();
    set_addr(8'h0E);
    i_mst.rd_byte(1'b0, d);
    chk_byte(d, 8'h11);
    i_mst.rd_byte(1'b1, d);
    chk_byte(d, 8'h22);
    i_mst.stop();
    $display("test wrap done");
  endtask

  task automatic t_strap();
    logic k;
    @(posedge clk_sys_i);
    pin <= 1'b1;
    ld <= 1'b0;
    n_dac = 0;
    n_nv = 0;
    i_mst.start();
    i_mst.wr_byte(8'hC0, k);
    chk_bit(k, 1'b1);
    i_mst.wr_byte(8'h05, k);
    chk_bit(k, 1'b1);
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte(8'hC2, k);
    chk_bit(k, 1'b0);
    i_mst.wr_byte(8'h20, k);
    i_mst.wr_byte(8'h5A, k);
    i_mst.stop();
    repeat (8) @(posedge clk_sys_i);
    chk_byte(8'(n_dac), 8'h00);
    chk_byte(8'(n_nv), 8'h01);
    wait_free();
    @(posedge clk_sys_i);
    pin <= 1'b0;
    ld <= 1'b1;
    $display("test strap done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence; link side needs clock pulses while in reset
  initial begin
    repeat (2) @(posedge clk_sys_i);
    i_mst.pulses(3);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // Link engine leaves reset only on serial-clock falling edges
    i_mst.pulses(3);
    t_write_read();
    t_wrap();
    t_strap();
    finish_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
